// *** design/iocs_pkg.sv ***
// constants and carrier types for the io channel control/status block
`default_nettype none
package iocs_pkg;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned NERR        = 4;
    // register numbers within the device address
    localparam logic [2:0]  REG_IN_DATA  = 3'h0;
    localparam logic [2:0]  REG_IN_STAT  = 3'h2;
    localparam logic [2:0]  REG_IN_CTRL  = 3'h3;
    localparam logic [2:0]  REG_OUT_DATA = 3'h5;
    localparam logic [2:0]  REG_OUT_STAT = 3'h6;
    localparam logic [2:0]  REG_OUT_CTRL = 3'h7;
    // control bit positions
    localparam int unsigned CB_EOI  = 0;
    localparam int unsigned CB_ERI  = 1;
    localparam int unsigned CB_ACT  = 2;
    localparam int unsigned CB_TEST = 3;
    localparam int unsigned CB_CLR  = 4;
    // status bit positions
    localparam int unsigned SB_RFT  = 3;
    localparam int unsigned SB_ERR  = 4;
    localparam int unsigned SB_ERR0 = 5;
    // reset values
    localparam logic [3:0]  CTRL_RST = 4'h0;
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef struct packed {
        logic        strobe;
        logic        write;
        logic [2:0]  regNo;
        logic [15:0] data;
    } iocs_req_s;
endpackage : iocs_pkg
`default_nettype wire

// *** design/iocs_chan_regs.sv ***
// per-channel control register, latched errors and status word
`default_nettype none
module iocs_chan_regs (
    input  wire logic        ref_clk,   // system clock
    input  wire logic        rst_b,     // master clear, active low
    input  wire logic        ctrlWe,    // host write of this control register
    input  wire logic [15:0] ctrlData,  // written control word
    input  wire logic        devClr,    // device clear, both channels
    input  wire logic        ready,     // ready for transfer
    input  wire logic [3:0]  errSet,    // error event pulses
    output logic      [3:0]  ctrl,      // stored control bits 0-3
    output logic      [15:0] status,    // assembled status word
    output logic             eoReq,     // end-of-operation request
    output logic             errReq     // error request
);
    logic [3:0] ctrl_q;
    logic [3:0] ctrl_d;
    logic [3:0] err_q;
    logic [3:0] err_d;

    always_comb
    begin
        ctrl_d = ctrl_q;
        err_d  = err_q | errSet;
        if (devClr)
        begin
            ctrl_d = iocs_pkg::CTRL_RST;
            err_d  = errSet;                    // a new error still wins over clear
        end
        else if (ctrlWe)
        begin
            ctrl_d = ctrlData[3:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= iocs_pkg::CTRL_RST;
            err_q  <= iocs_pkg::CTRL_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            err_q  <= err_d;
        end
    end

    assign ctrl   = ctrl_q;
    // bits 9-15 carry no device-specific meaning here
    assign status = {7'h00, err_q, |err_q, ready, ctrl_q[2:0]};
    assign eoReq  = ctrl_q[iocs_pkg::CB_EOI] & ready;
    assign errReq = ctrl_q[iocs_pkg::CB_ERI] & status[iocs_pkg::SB_ERR];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    ctrl_mirror_a: assert property (ctrlWe && !devClr |=> status[2:0] == $past(ctrlData[2:0]))
        else $error("status low bits do not mirror control");
    act_hold_a: assert property (ctrl_q[2] && !ctrlWe && !devClr |=> ctrl_q[2])
        else $error("activate bit dropped without cause");
    err_or_a: assert property (|errSet |=> status[iocs_pkg::SB_ERR])
        else $error("error summary bit not set");
    err_hold_a: assert property (status[iocs_pkg::SB_ERR] && !devClr
        |=> status[iocs_pkg::SB_ERR])
        else $error("error summary bit dropped without clear");
endmodule : iocs_chan_regs
`default_nettype wire

// *** design/iocs_io_channel.sv ***
// two-channel programmed io interface: control, status, data and loopback
`default_nettype none
// Function
// - status bits 0-2 mirror control bits
// - input ready means data word waiting
// - output ready means data register empty
// - status bit 4 ORs all error bits
// - same bit layout on both channels
// - every control write acts at once
// - ready plus bit 0 raises interrupt
// - bit 1 clear blocks error interrupt
// - activate starts reception or sending
// - activate stays set until cleared
// - test bit loops output into input
// - clear bit resets control and status
// - device clear resets both channels
// - error and bit 1 raise interrupt
// - control write-only, status read-only
module iocs_io_channel (
    input  wire logic              ref_clk,     // system clock, 100 MHz
    input  wire logic              rst_b,       // master clear, active low
    input  wire iocs_pkg::iocs_req_s hostReq,   // io transfer request from cpu
    output logic      [15:0]       hostRdData,  // read answer, one cycle later
    input  wire logic              extInValid,  // external word offered
    input  wire logic [15:0]       extInData,   // external input word
    output logic                   extInReady,  // input channel accepts word
    output logic                   extOutValid, // output word offered
    output logic      [15:0]       extOutData,  // output word
    input  wire logic              extOutReady, // external device takes word
    input  wire logic [3:0]        inErrSet,    // input channel error pulses
    input  wire logic [3:0]        outErrSet,   // output channel error pulses
    output logic                   inEoIrq,     // input end-of-operation request
    output logic                   inErrIrq,    // input error request
    output logic                   outEoIrq,    // output end-of-operation request
    output logic                   outErrIrq    // output error request
);
    logic        rd, wr, inCtrlWe, outCtrlWe, devClr, testMode;
    logic        loopMove, extTake, extDone;
    logic [3:0]  inCtrl, outCtrl;
    logic [15:0] inStat, outStat;
    logic        inEoReq, inErrReq, outEoReq, outErrReq;
    logic        inFull_q, inFull_d, outFull_q, outFull_d;
    logic [15:0] inData_q, inData_d, outData_q, outData_d, rdData_q, rdData_d;
    logic        inReady_q, inReady_d, outValid_q, outValid_d;
    logic [3:0]  irq_q, irq_d;

    assign rd        = hostReq.strobe & ~hostReq.write;
    assign wr        = hostReq.strobe & hostReq.write;
    assign inCtrlWe  = wr & (hostReq.regNo == iocs_pkg::REG_IN_CTRL);
    assign outCtrlWe = wr & (hostReq.regNo == iocs_pkg::REG_OUT_CTRL);
    // clear is honoured on either control register, not just the input one
    assign devClr    = (inCtrlWe | outCtrlWe) & hostReq.data[iocs_pkg::CB_CLR];
    assign testMode  = inCtrl[iocs_pkg::CB_TEST] | outCtrl[iocs_pkg::CB_TEST];
    // a word already offered outside is left to finish there, never sent twice
    assign loopMove  = testMode & outFull_q & outCtrl[iocs_pkg::CB_ACT] & ~outValid_q
                     & inCtrl[iocs_pkg::CB_ACT] & ~inFull_q;
    assign extTake   = extInValid & inReady_q;
    assign extDone   = outValid_q & extOutReady;

    // identical register logic serves both directions
    iocs_chan_regs u_inRegs (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .ctrlWe   (inCtrlWe),
        .ctrlData (hostReq.data),
        .devClr   (devClr),
        .ready    (inFull_q),
        .errSet   (inErrSet),
        .ctrl     (inCtrl),
        .status   (inStat),
        .eoReq    (inEoReq),
        .errReq   (inErrReq)
    );

    // no block-transfer engine: ready tracks the data register alone
    iocs_chan_regs u_outRegs (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .ctrlWe   (outCtrlWe),
        .ctrlData (hostReq.data),
        .devClr   (devClr),
        .ready    (~outFull_q),
        .errSet   (outErrSet),
        .ctrl     (outCtrl),
        .status   (outStat),
        .eoReq    (outEoReq),
        .errReq   (outErrReq)
    );

    always_comb
    begin
        inFull_d  = inFull_q;
        inData_d  = inData_q;
        outFull_d = outFull_q;
        outData_d = outData_q;
        rdData_d  = rdData_q;
        if (rd && hostReq.regNo == iocs_pkg::REG_IN_DATA && inFull_q)
        begin
            inFull_d = 1'b0;
        end
        if (extDone || loopMove)
        begin
            outFull_d = 1'b0;
        end
        // relies on the host writing data only while ready
        if (wr && hostReq.regNo == iocs_pkg::REG_OUT_DATA)
        begin
            outData_d = hostReq.data;
            outFull_d = 1'b1;
        end
        if (loopMove)
        begin
            inData_d = outData_q;
            inFull_d = 1'b1;
        end
        if (extTake)
        begin
            inData_d = extInData;
            inFull_d = 1'b1;
        end
        if (devClr)
        begin
            inFull_d  = 1'b0;
            outFull_d = 1'b0;
        end
        if (rd)
        begin
            case (hostReq.regNo)
                iocs_pkg::REG_IN_DATA:  rdData_d = inData_q;
                iocs_pkg::REG_IN_STAT:  rdData_d = inStat;
                iocs_pkg::REG_OUT_STAT: rdData_d = outStat;
                default:                rdData_d = iocs_pkg::WORD_RST;
            endcase
        end
        // reception opens only on activate; a control write closes it for a cycle
        inReady_d  = inCtrl[iocs_pkg::CB_ACT] & ~testMode & ~inFull_d
                   & ~inCtrlWe & ~outCtrlWe;
        // an offered word stays offered until taken, except on clear
        outValid_d = ~devClr & ((outValid_q & ~extDone)
                   | (outCtrl[iocs_pkg::CB_ACT] & ~testMode & outFull_d & ~outValid_q
                      & ~inCtrlWe & ~outCtrlWe));
        irq_d = {outErrReq, outEoReq, inErrReq, inEoReq};
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            inFull_q   <= 1'b0;
            outFull_q  <= 1'b0;
            inData_q   <= iocs_pkg::WORD_RST;
            outData_q  <= iocs_pkg::WORD_RST;
            rdData_q   <= iocs_pkg::WORD_RST;
            inReady_q  <= 1'b0;
            outValid_q <= 1'b0;
            irq_q      <= 4'h0;
        end
        else
        begin
            inFull_q   <= inFull_d;
            outFull_q  <= outFull_d;
            inData_q   <= inData_d;
            outData_q  <= outData_d;
            rdData_q   <= rdData_d;
            inReady_q  <= inReady_d;
            outValid_q <= outValid_d;
            irq_q      <= irq_d;
        end
    end

    assign hostRdData  = rdData_q;
    assign extInReady  = inReady_q;
    assign extOutValid = outValid_q;
    assign extOutData  = outData_q;
    assign inEoIrq     = irq_q[0];
    assign inErrIrq    = irq_q[1];
    assign outEoIrq    = irq_q[2];
    assign outErrIrq   = irq_q[3];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    in_rd_clr_a: assert property (rd && hostReq.regNo == 3'h0 && inFull_q
        |=> !inFull_q && !inStat[3])
        else $error("input read did not clear ready");
    out_wr_busy_a: assert property (wr && hostReq.regNo == 3'h5 && !devClr
        |=> outFull_q && !outStat[3] && extOutData == $past(hostReq.data))
        else $error("output write did not mark busy");
    in_take_a: assert property (extTake && !devClr
        |=> inStat[3] && inData_q == $past(extInData))
        else $error("received word not flagged ready");
    dev_clr_a: assert property (devClr
        |=> inCtrl == 4'h0 && outCtrl == 4'h0 && !inFull_q && !outFull_q)
        else $error("device clear left state behind");
    eo_irq_a: assert property (inCtrl[0] && inStat[3] |=> inEoIrq)
        else $error("end-of-operation request missing");
    err_block_a: assert property (!outCtrl[1] |=> !outErrIrq)
        else $error("error request while disabled");
    err_irq_a: assert property (inStat[4] && inCtrl[1] |=> inErrIrq)
        else $error("error request missing");
    loop_move_a: assert property (loopMove && !devClr
        |=> inFull_q && inData_q == $past(outData_q) && !extOutValid)
        else $error("loopback word not moved");
    send_start_a: assert property (outFull_q && outCtrl[2] && !testMode && !outValid_q
        && !inCtrlWe && !outCtrlWe |=> extOutValid)
        else $error("activate did not start sending");
    ctrl_cmd_a: assert property (inCtrlWe && !devClr
        |=> inCtrl == $past(hostReq.data[3:0]))
        else $error("control write not taken at once");
    ctrl_rd_a: assert property (rd && hostReq.regNo == 3'h3 |=> hostRdData == 16'h0000)
        else $error("control register readable");

    in_rx_c:   cover property (extTake ##[1:20] (rd && hostReq.regNo == 3'h0));
    out_tx_c:  cover property ((wr && hostReq.regNo == 3'h5) ##[1:20] extDone);
    loop_c:    cover property (loopMove);
    clr_c:     cover property (devClr && inFull_q);
endmodule : iocs_io_channel
`default_nettype wire

// *** verif/iocs_ext_dev.sv ***
// behavioural external device: word source for input, stallable sink for output
`default_nettype none
module iocs_ext_dev (
    input  wire logic        ref_clk,     // system clock
    input  wire logic        rst_b,       // master clear, active low
    output logic             extInValid,  // word offered to input
    output logic      [15:0] extInData,   // offered word
    input  wire logic        extInReady,  // input channel accepts
    input  wire logic        extOutValid, // output word offered
    input  wire logic [15:0] extOutData,  // output word
    output logic             extOutReady, // sink takes word
    input  wire logic        sinkStall,   // hold the sink off
    output logic      [15:0] gotWord      // last word taken
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        extInValid = 1'b0;
        extInData  = 16'h5555;
    end

    // word is held until the channel takes it or 200 more cycles pass
    task automatic offer(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge ref_clk);
        extInValid <= 1'b1;
        extInData  <= w;
        @(posedge ref_clk);
        while (extInReady !== 1'b1 && n < 200)
        begin
            @(posedge ref_clk);
            n++;
        end
        extInValid <= 1'b0;
        // a released line never keeps showing the old word
        extInData  <= ~w;
    endtask : offer

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            extOutReady <= 1'b0;
            gotWord     <= 16'h0000;
        end
        else
        begin
            extOutReady <= !sinkStall;
            if (extOutValid && extOutReady)
                gotWord <= extOutData;
        end
    end
endmodule : iocs_ext_dev
`default_nettype wire

// *** verif/iocs_io_channel_tb.sv ***
// bench: host register sequences against the two-channel io block
`default_nettype none
module iocs_io_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                ref_clk, rst_b, extInValid, extInReady, extOutValid, extOutReady;
    logic                inEoIrq, inErrIrq, outEoIrq, outErrIrq, sinkStall;
    logic [15:0]         hostRdData, extInData, extOutData, gotWord, rdVal;
    logic [3:0]          inErrSet, outErrSet;
    iocs_pkg::iocs_req_s hostReq;
    int                  nMismatch = 0, testsRun = 0, cycles = 0;

    iocs_io_channel dut (.ref_clk(ref_clk), .rst_b(rst_b), .hostReq(hostReq),
        .hostRdData(hostRdData), .extInValid(extInValid), .extInData(extInData),
        .extInReady(extInReady), .extOutValid(extOutValid), .extOutData(extOutData),
        .extOutReady(extOutReady), .inErrSet(inErrSet), .outErrSet(outErrSet),
        .inEoIrq(inEoIrq), .inErrIrq(inErrIrq), .outEoIrq(outEoIrq),
        .outErrIrq(outErrIrq));
    iocs_ext_dev ext (.ref_clk(ref_clk), .rst_b(rst_b), .extInValid(extInValid),
        .extInData(extInData), .extInReady(extInReady), .extOutValid(extOutValid),
        .extOutData(extOutData), .extOutReady(extOutReady), .sinkStall(sinkStall),
        .gotWord(gotWord));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            nMismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // one io transfer; read answer is taken the cycle after the strobe
    task automatic access(input logic wr, input logic [2:0] r, input logic [15:0] d);
        @(posedge ref_clk);
        hostReq <= {1'b1, wr, r, d};
        @(posedge ref_clk);
        hostReq <= '0;
        #1;
        rdVal = hostRdData;
    endtask : access

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkBit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chkBit

    task automatic rdChk(input logic [2:0] r, input logic [15:0] exp);
        access(1'b0, r, 16'h0000);
        chk(rdVal, exp);
    endtask : rdChk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    // host never moves data before the ready bit shows
    task automatic poll(input logic [2:0] r);
        int n;
        n = 0;
        rdVal = 16'h0000;
        while (rdVal[3] !== 1'b1 && n < 100)
        begin
            access(1'b0, r, 16'h0000);
            n++;
        end
        chkBit(rdVal[3], 1'b1);
    endtask : poll

    initial
    begin
        rst_b     = 1'b0;
        hostReq   = '0;
        inErrSet  = 4'h0;
        outErrSet = 4'h0;
        sinkStall = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdChk(3'h2, 16'h0000);
        rdChk(3'h6, 16'h0008);
        rdChk(3'h3, 16'h0000);
        rdChk(3'h1, 16'h0000);
        $display("test reset done");
        access(1'b1, 3'h3, 16'h0007);
        rdChk(3'h2, 16'h0007);
        chkBit(extInReady, 1'b1);
        ext.offer(16'h1234);
        poll(3'h2);
        chk(rdVal, 16'h000f);
        chkBit(extInReady, 1'b0);
        idle(2);
        chkBit(inEoIrq, 1'b1);
        rdChk(3'h0, 16'h1234);
        rdChk(3'h2, 16'h0007);
        idle(2);
        chkBit(inEoIrq, 1'b0);
        $display("test input done");
        @(posedge ref_clk);
        inErrSet <= 4'h2;
        @(posedge ref_clk);
        inErrSet <= 4'h0;
        rdChk(3'h2, 16'h0057);
        chkBit(inErrIrq, 1'b1);
        access(1'b1, 3'h3, 16'h0005);
        rdChk(3'h2, 16'h0055);
        chkBit(inErrIrq, 1'b0);
        @(posedge ref_clk);
        outErrSet <= 4'h8;
        @(posedge ref_clk);
        outErrSet <= 4'h0;
        access(1'b1, 3'h7, 16'h0002);
        rdChk(3'h6, 16'h011a);
        chkBit(outErrIrq, 1'b1);
        access(1'b1, 3'h3, 16'h0010);
        rdChk(3'h2, 16'h0000);
        rdChk(3'h6, 16'h0008);
        chkBit(outErrIrq, 1'b0);
        $display("test error and clear done");
        @(posedge ref_clk);
        sinkStall <= 1'b1;
        poll(3'h6);
        access(1'b1, 3'h5, 16'hbeef);
        rdChk(3'h6, 16'h0000);
        access(1'b1, 3'h7, 16'h0005);
        idle(4);
        chkBit(extOutValid, 1'b1);
        chk(extOutData, 16'hbeef);
        rdChk(3'h6, 16'h0005);
        @(posedge ref_clk);
        sinkStall <= 1'b0;
        poll(3'h6);
        chk(gotWord, 16'hbeef);
        chk(rdVal, 16'h000d);
        idle(2);
        chkBit(outEoIrq, 1'b1);
        $display("test output done");
        access(1'b1, 3'h6, 16'hffff);
        rdChk(3'h6, 16'h000d);
        access(1'b1, 3'h3, 16'h000c);
        access(1'b1, 3'h5, 16'h5a5a);
        poll(3'h2);
        rdChk(3'h0, 16'h5a5a);
        chk(gotWord, 16'hbeef);
        $display("test loopback done");
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdChk(3'h2, 16'h0000);
        rdChk(3'h6, 16'h0008);
        $display("test master clear done");
        give_verdict();
    end
endmodule : iocs_io_channel_tb
`default_nettype wire
